//--- core/fps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [fps_pkg::ADDR_W-1:0] i_first_addr,
	input wire logic [fps_pkg::COUNT_W-1:0] i_word_count,
	input wire logic i_step_mode,
	input wire logic [fps_pkg::DATA_W-1:0] i_word,
	input wire logic i_word_valid,
	output logic o_word_ready,
	output logic o_busy,
	output logic o_verify_phase,
	output logic o_done,
	output logic o_fail,
	output logic [7:0] o_status,
	output logic o_vpp_enable,
	output logic [fps_pkg::ADDR_W-1:0] o_flash_addr,
	output logic [fps_pkg::DATA_W-1:0] o_flash_dq,
	output logic o_flash_dq_oe,
	input wire logic [fps_pkg::DATA_W-1:0] i_flash_dq,
	output logic o_flash_ce_n,
	output logic o_flash_we_n,
	output logic o_flash_oe_n
);
	import fps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	fps_state_type state_reg, state_next;
	fps_state_type ret_reg, ret_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic [ADDR_W-1:0] first_reg, first_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [COUNT_W-1:0] count_reg, count_next;
	logic [COUNT_W-1:0] idx_reg, idx_next;
	logic step_reg, step_next;
	logic verify_reg, verify_next;
	logic [7:0] status_reg, status_next;
	logic fail_reg, fail_next;
	logic done_reg, done_next;
	logic vpp_reg, vpp_next;

	////////////////////////////////////////////////////////////////////////
	// Decoding
	wire logic timer_zero;
	wire logic [TIMER_W-1:0] timer_dec;
	wire logic [ADDR_W-1:0] stream_addr;
	wire logic last_word;
	wire logic stream_busy;
	wire logic bus_wr;
	wire logic bus_rd;

	assign timer_zero = (timer_reg == '0);
	assign timer_dec = timer_reg - TIMER_W'(1);
	assign stream_addr = step_reg ? (first_reg + ADDR_W'(idx_reg)) : first_reg;
	assign last_word = (idx_reg == count_reg);
	assign stream_busy = status_reg[STREAM_READY_BIT];
	assign bus_wr = (state_reg == ST_BUS_WR);
	assign bus_rd = (state_reg == ST_BUS_RD);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		state_next = state_reg;
		ret_next = ret_reg;
		timer_next = timer_reg;
		first_next = first_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		count_next = count_reg;
		idx_next = idx_reg;
		step_next = step_reg;
		verify_next = verify_reg;
		status_next = status_reg;
		fail_next = fail_reg;
		done_next = 1'b0;
		vpp_next = vpp_reg;
		case (state_reg)
			ST_IDLE: begin
				if (i_start) begin
					first_next = i_first_addr;
					count_next = i_word_count;
					step_next = i_step_mode;
					idx_next = '0;
					verify_next = 1'b0;
					fail_next = 1'b0;
					vpp_next = 1'b1;
					timer_next = VPP_SETTLE_CYCLES;
					state_next = ST_VPP_WAIT;
				end
			end
			ST_VPP_WAIT: begin
				if (timer_zero) begin
					addr_next = first_reg;
					wdata_next = CMD_UNLOCK_SETUP;
					ret_next = ST_UNLOCK_CONFIRM;
					timer_next = BUS_STROBE_CYCLES;
					state_next = ST_BUS_WR;
				end else begin
					timer_next = timer_dec;
				end
			end
			ST_UNLOCK_CONFIRM: begin
				wdata_next = CMD_UNLOCK_CONFIRM;
				ret_next = ST_EFP_SETUP;
				timer_next = BUS_STROBE_CYCLES;
				state_next = ST_BUS_WR;
			end
			ST_EFP_SETUP: begin
				wdata_next = CMD_EFP_SETUP;
				ret_next = ST_EFP_CONFIRM;
				timer_next = BUS_STROBE_CYCLES;
				state_next = ST_BUS_WR;
			end
			ST_EFP_CONFIRM: begin
				wdata_next = CMD_EFP_CONFIRM;
				ret_next = ST_SETUP_WAIT;
				timer_next = BUS_STROBE_CYCLES;
				state_next = ST_BUS_WR;
			end
			ST_SETUP_WAIT: begin
				if (timer_zero) begin
					ret_next = ST_SETUP_CHECK;
					timer_next = BUS_STROBE_CYCLES;
					state_next = ST_BUS_RD;
				end else begin
					timer_next = timer_dec;
				end
			end
			ST_SETUP_CHECK: begin
				if (status_reg[ENGINE_READY_BIT]) begin
					fail_next = 1'b1;
					state_next = ST_FINISH;
				end else begin
					state_next = ST_PRE_POLL;
				end
			end
			ST_PRE_POLL: begin
				ret_next = ST_PRE_CHECK;
				timer_next = BUS_STROBE_CYCLES;
				state_next = ST_BUS_RD;
			end
			ST_PRE_CHECK: begin
				if (stream_busy) begin
					state_next = ST_PRE_POLL;
				end else if (last_word) begin
					state_next = ST_END_PHASE;
				end else begin
					state_next = ST_GET_WORD;
				end
			end
			ST_GET_WORD: begin
				if (i_word_valid) begin
					addr_next = stream_addr;
					wdata_next = i_word;
					ret_next = ST_POST_POLL;
					timer_next = BUS_STROBE_CYCLES;
					state_next = ST_BUS_WR;
				end
			end
			ST_POST_POLL: begin
				ret_next = ST_POST_CHECK;
				timer_next = BUS_STROBE_CYCLES;
				state_next = ST_BUS_RD;
			end
			ST_POST_CHECK: begin
				if (stream_busy) begin
					state_next = ST_POST_POLL;
				end else begin
					idx_next = idx_reg + COUNT_W'(1);
					state_next = ST_PRE_POLL;
				end
			end
			ST_END_PHASE: begin
				addr_next = fps_exit_address(first_reg);
				wdata_next = EXIT_WORD;
				ret_next = verify_reg ? ST_EXIT_POLL : ST_START_VERIFY;
				timer_next = BUS_STROBE_CYCLES;
				state_next = ST_BUS_WR;
			end
			ST_START_VERIFY: begin
				verify_next = 1'b1;
				idx_next = '0;
				state_next = ST_PRE_POLL;
			end
			ST_EXIT_POLL: begin
				ret_next = ST_EXIT_CHECK;
				timer_next = BUS_STROBE_CYCLES;
				state_next = ST_BUS_RD;
			end
			ST_EXIT_CHECK: begin
				state_next = status_reg[ENGINE_READY_BIT] ? ST_FULL_CHECK : ST_EXIT_POLL;
			end
			ST_FULL_CHECK: begin
				fail_next = status_reg[PROGRAM_FAILURE_BIT] | status_reg[SUPPLY_VOLTAGE_ERROR_BIT] |
					status_reg[LOCKED_BLOCK_ERROR_BIT];
				state_next = ST_FINISH;
			end
			ST_FINISH: begin
				vpp_next = 1'b0;
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
			ST_BUS_WR: begin
				if (timer_zero) begin
					timer_next = SETUP_DELAY_CYCLES;
					state_next = ret_reg;
				end else begin
					timer_next = timer_dec;
				end
			end
			ST_BUS_RD: begin
				if (timer_zero) begin
					status_next = i_flash_dq[7:0];
					state_next = ret_reg;
				end else begin
					timer_next = timer_dec;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			ret_reg <= ST_IDLE;
			timer_reg <= '0;
			first_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			count_reg <= '0;
			idx_reg <= '0;
			step_reg <= 1'b0;
			verify_reg <= 1'b0;
			status_reg <= '0;
			fail_reg <= 1'b0;
			done_reg <= 1'b0;
			vpp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ret_reg <= ret_next;
			timer_reg <= timer_next;
			first_reg <= first_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			count_reg <= count_next;
			idx_reg <= idx_next;
			step_reg <= step_next;
			verify_reg <= verify_next;
			status_reg <= status_next;
			fail_reg <= fail_next;
			done_reg <= done_next;
			vpp_reg <= vpp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_word_ready = (state_reg == ST_GET_WORD);
	assign o_busy = (state_reg != ST_IDLE);
	assign o_verify_phase = verify_reg;
	assign o_done = done_reg;
	assign o_fail = fail_reg;
	assign o_status = status_reg;
	assign o_vpp_enable = vpp_reg;
	assign o_flash_addr = addr_reg;
	assign o_flash_dq = wdata_reg;
	assign o_flash_dq_oe = bus_wr;
	assign o_flash_ce_n = ~(bus_wr | bus_rd);
	assign o_flash_we_n = ~bus_wr;
	assign o_flash_oe_n = ~bus_rd;

endmodule
`default_nettype wire

//--- pkg/fps_pkg.sv
package fps_pkg;

	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int COUNT_W = 16;
	localparam int TIMER_W = 12;
	localparam int BLOCK_LSB = 15;

	localparam logic [DATA_W-1:0] CMD_UNLOCK_SETUP = 16'h0060;
	localparam logic [DATA_W-1:0] CMD_UNLOCK_CONFIRM = 16'h00D0;
	localparam logic [DATA_W-1:0] CMD_EFP_SETUP = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_EFP_CONFIRM = 16'h00D0;
	localparam logic [DATA_W-1:0] EXIT_WORD = 16'hFFFF;

	localparam int ENGINE_READY_BIT = 7;
	localparam int PROGRAM_FAILURE_BIT = 4;
	localparam int SUPPLY_VOLTAGE_ERROR_BIT = 3;
	localparam int LOCKED_BLOCK_ERROR_BIT = 1;
	localparam int STREAM_READY_BIT = 0;

	localparam int CLOCK_MHZ = 125;
	localparam int VPP_SETTLE_NS = 2000;
	localparam int SETUP_DELAY_NS = 1000;
	localparam int BUS_STROBE_NS = 70;
	localparam logic [TIMER_W-1:0] VPP_SETTLE_CYCLES = TIMER_W'((VPP_SETTLE_NS * CLOCK_MHZ + 999) / 1000);
	localparam logic [TIMER_W-1:0] SETUP_DELAY_CYCLES = TIMER_W'((SETUP_DELAY_NS * CLOCK_MHZ + 999) / 1000);
	localparam logic [TIMER_W-1:0] BUS_STROBE_CYCLES = TIMER_W'((BUS_STROBE_NS * CLOCK_MHZ + 999) / 1000);

	typedef enum logic [4:0] {
		ST_IDLE, ST_VPP_WAIT, ST_UNLOCK_CONFIRM, ST_EFP_SETUP, ST_EFP_CONFIRM,
		ST_SETUP_WAIT, ST_SETUP_CHECK, ST_PRE_POLL, ST_PRE_CHECK, ST_GET_WORD,
		ST_POST_POLL, ST_POST_CHECK, ST_END_PHASE, ST_START_VERIFY, ST_EXIT_POLL,
		ST_EXIT_CHECK, ST_FULL_CHECK, ST_FINISH, ST_BUS_WR, ST_BUS_RD
	} fps_state_type;

	function automatic logic [ADDR_W-1:0] fps_exit_address(input logic [ADDR_W-1:0] first);
		fps_exit_address = first ^ (ADDR_W'(1) << BLOCK_LSB);
	endfunction

endpackage

//--- tb/fps_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model (
	input wire logic i_clock,
	input wire logic i_slow,
	input wire logic i_miss,
	input wire logic [1:0] i_err,
	input wire logic [fps_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fps_pkg::DATA_W-1:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	output logic [fps_pkg::DATA_W-1:0] o_dq
);
	import fps_pkg::*;
	logic [DATA_W-1:0] mem [256];
	logic [ADDR_W-1:0] wa0 = 0, ptr = 0, a;
	logic [1:0] ph = 0, n = 0;
	logic [5:0] bz = 0;
	logic e7 = 0, lk = 0, fl = 0, wl = 1, b7;
	logic [7:0] sr;
	assign a = (i_addr == wa0) ? ptr : i_addr;
	assign b7 = (ph == 0) ? 1'b1 : (ph == 3 && bz == 0);
	assign sr = {b7, 2'b00, fl, e7, 1'b0, lk, |bz};
	assign o_dq = (!i_ce_n && !i_oe_n) ? {8'h00, sr} : ~{8'h00, sr};
	always @(posedge i_clock) begin
		wl <= i_we_n;
		if (bz != 0) bz <= bz - 1;
		if (!i_ce_n && !i_we_n && wl) begin
			if (ph == 0 || ph == 3) begin
				n <= n + 1;
				ph <= 0;
				e7 <= 0;
				lk <= 0;
				if (n == 0) fl <= 0;
				if (n == 3) begin
					wa0 <= i_addr;
					ptr <= i_addr;
					e7 <= i_err[0];
					lk <= i_err[1];
					ph <= {1'b0, !(|i_err)};
				end
			end else if (bz == 0) begin
				if (i_dq == EXIT_WORD && i_addr[22:15] != wa0[22:15]) begin
					ph <= ph + 1;
					ptr <= wa0;
					bz <= 20;
				end else if (ph == 1) begin
					mem[a[7:0]] <= i_dq;
					ptr <= a + 1;
					bz <= i_slow ? 40 : 3;
				end else begin
					ptr <= a + 1;
					bz <= (i_miss || mem[a[7:0]] != i_dq) ? 50 : 3;
					fl <= fl | i_miss;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/fps_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_chk (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_step_mode,
	input wire logic [fps_pkg::ADDR_W-1:0] i_first_addr,
	input wire logic o_busy,
	input wire logic o_verify_phase,
	input wire logic o_done,
	input wire logic o_fail,
	input wire logic [7:0] o_status,
	input wire logic o_vpp_enable,
	input wire logic o_word_ready,
	input wire logic [fps_pkg::ADDR_W-1:0] o_flash_addr,
	input wire logic [fps_pkg::DATA_W-1:0] o_flash_dq,
	input wire logic o_flash_ce_n,
	input wire logic o_flash_we_n
);
	import fps_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_wr;
		$fell(o_flash_we_n);
	endsequence
	sequence s_vwr;
		s_wr ##0 o_verify_phase && !i_step_mode && o_flash_dq != EXIT_WORD;
	endsequence
	chk_bus_supply: assert property (!o_flash_ce_n |-> o_vpp_enable) else $error("bus without supply");
	chk_start_busy: assert property (i_start && !o_busy |=> o_busy) else $error("start lost");
	chk_write_ready: assert property (s_wr |-> !o_status[0]) else $error("write while busy");
	chk_word_ready: assert property (o_word_ready |-> !o_status[0]) else $error("word while busy");
	chk_strobe_held: assert property (s_wr |-> (!o_flash_we_n)[*8]) else $error("short strobe");
	chk_exit_block: assert property (s_wr ##0 o_flash_dq == EXIT_WORD |->
		o_flash_addr[22:15] != i_first_addr[22:15]) else $error("exit in block");
	chk_fixed_addr: assert property (s_vwr |-> o_flash_addr == i_first_addr) else $error("verify addr");
	chk_done_ready: assert property (o_done |-> o_status[7] ##1 !o_done && !o_busy) else $error("done");
	chk_fail_code: assert property (o_done |->
		o_fail == (o_status[4] | o_status[3] | o_status[1])) else $error("fail code");
	chk_verify_entry: assert property ($rose(o_verify_phase) |-> o_flash_dq == EXIT_WORD)
		else $error("verify entry");
endmodule
bind fps_sequencer fps_sequencer_chk u_chk (.i_clock, .i_rst, .i_start, .i_step_mode, .i_first_addr, .o_busy,
	.o_verify_phase, .o_done, .o_fail, .o_status, .o_vpp_enable, .o_word_ready, .o_flash_addr, .o_flash_dq,
	.o_flash_ce_n, .o_flash_we_n);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fps_pkg::*;
	logic i_clock = 0, i_rst = 1, i_start = 0, i_step_mode = 0, i_word_valid = 0;
	logic slow = 0, miss = 0, ready, done, fail, oe, busy, vpp, vph;
	logic [1:0] err = 0;
	logic [ADDR_W-1:0] first = 0, addr;
	logic [COUNT_W-1:0] cnt = 0;
	logic [DATA_W-1:0] word = 0, dq_o, dq_m, dq;
	logic [7:0] st;
	logic [2:0] cn;
	int fails, check_count, cyc, k, vk;
	assign dq = oe ? dq_o : dq_m;
	fps_sequencer dut (.i_clock, .i_rst, .i_start, .i_first_addr(first), .i_word_count(cnt), .i_step_mode,
		.i_word(word), .i_word_valid, .o_word_ready(ready), .o_busy(busy), .o_verify_phase(vph), .o_done(done),
		.o_fail(fail), .o_status(st), .o_vpp_enable(vpp), .o_flash_addr(addr), .o_flash_dq(dq_o),
		.o_flash_dq_oe(oe), .i_flash_dq(dq), .o_flash_ce_n(cn[0]), .o_flash_we_n(cn[1]), .o_flash_oe_n(cn[2]));
	fps_flash_model mdl (.i_clock, .i_slow(slow), .i_miss(miss), .i_err(err), .i_addr(addr), .i_dq(dq),
		.i_ce_n(cn[0]), .i_we_n(cn[1]), .i_oe_n(cn[2]), .o_dq(dq_m));
	initial forever #4 i_clock = ~i_clock;
	always @(posedge i_clock) if (++cyc == 30000) begin
		fails++;
		test_done;
	end
	always @(posedge i_clock) if (ready && i_word_valid) begin
		k = k + 1;
		vk = vk + int'(vph);
		word <= 16'h1200 + 16'(k % cnt);
	end
	task automatic chk(input string nm, input logic [15:0] got, exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic run(input logic [ADDR_W-1:0] f, input int c, input logic s, ef);
		first <= f;
		cnt <= COUNT_W'(c);
		i_step_mode <= s;
		word <= 16'h1200;
		k = 0;
		vk = 0;
		i_start <= 1;
		i_word_valid <= 1;
		@(posedge i_clock);
		i_start <= 0;
		do @(negedge i_clock); while (done !== 1'b1);
		chk("fail", 16'(fail), 16'(ef));
		chk("engine ready", 16'(st[7]), 16'h0001);
		chk("busy", 16'(busy), 16'h0000);
		chk("supply", 16'(vpp), 16'h0000);
		chk("verify words", 16'(vk), 16'(err ? 0 : c));
		chk("stream words", 16'(k), 16'(err ? 0 : 2 * c));
		for (int i = 0; i < c && !err; i++) chk("mem", mdl.mem[f[7:0] + 8'(i)], 16'h1200 + 16'(i));
		@(posedge i_clock);
	endtask
	task automatic t_fixed;
		run(23'h00_8010, 3, 0, 0);
	endtask
	task automatic t_step;
		slow <= 1;
		run(23'h01_0020, 4, 1, 0);
		slow <= 0;
	endtask
	task automatic t_miss;
		miss <= 1;
		run(23'h00_0040, 2, 0, 1);
		chk("failure bit", 16'(st[4]), 16'h0001);
		miss <= 0;
	endtask
	task automatic t_err;
		for (int j = 1; j < 3; j++) begin
			err <= 2'(j);
			run(23'h00_0050, 2, 0, 1);
			chk("supply bit", 16'(st[3]), 16'(j == 1));
			chk("locked bit", 16'(st[1]), 16'(j == 2));
			chk("words", 16'(k), 16'h0000);
		end
		err <= 0;
	endtask
	initial begin
		repeat (4) @(posedge i_clock);
		i_rst <= 0;
		@(posedge i_clock);
		t_fixed;
		t_step;
		t_miss;
		t_err;
		test_done;
	end
endmodule
`default_nettype wire
